// ==== core/pad_device.sv ====
// Device end: register file, calibration timer, output divider, phase adjust
// Assumes pins come from the controller, possibly asynchronous
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pad_device #(
    parameter int CNT_W = 24
) (
    input  wire logic     i_clk,
    input  wire logic     i_reset,
    pad_link_if.device    link,
    input  wire logic     i_init_done,
    output logic          o_cal_busy,
    output logic [4:0]    o_out_divisor,
    output logic          o_out_invert,
    output logic [11:0]   o_fb_integer,
    output logic [24:0]   o_primary_fraction,
    output logic [23:0]   o_auxiliary_fraction,
    output logic [23:0]   o_auxiliary_modulus,
    output logic          o_lock_lost,
    output logic [13:0]   o_phase_offset,
    output logic [7:0]    o_bleed_level
);
    // ************************************
    // Register storage
    // ************************************
    logic [7:0] fb_lo_r, fb_hi_r, cal_ctrl_r, pre_to_r, cnt_to_r, set_to_r;
    logic [7:0] phase_ctrl_r, init_lo_r, init_hi_r, step_r;
    logic [7:0] frac1_r [4];
    logic [7:0] frac2_r [3];
    logic [7:0] mod2_r [3];
    logic [7:0] bias_r [pad_pkg::BIAS_DEPTH];
    logic       bias_hit;
    logic [4:0] bias_idx;
    logic [13:0] acc_r;
    logic [7:0]  bleed_r;
    logic [7:0]  rdata_r;
    logic        ack_r;
    logic        wr_fb_lo;
    logic        sw_step;
    logic        sw_step_r;

    function automatic logic [4:0] div_of(input logic [2:0] code);
        case (code)
            3'h0: div_of = 5'h01;
            3'h1: div_of = 5'h02;
            3'h2: div_of = 5'h04;
            3'h3: div_of = 5'h08;
            default: div_of = 5'h10;
        endcase
    endfunction

    assign wr_fb_lo = link.reg_wr && link.reg_addr == pad_pkg::OFF_FB_INT_LOW;
    assign sw_step  = link.reg_wr && link.reg_addr == pad_pkg::OFF_PHASE_CTRL
                      && link.reg_wdata[pad_pkg::POS_SW_STEP];
    assign bias_hit = link.reg_addr >= pad_pkg::OFF_BIAS_FIRST
                      && link.reg_addr <= pad_pkg::OFF_BIAS_LAST;
    assign bias_idx = 5'(link.reg_addr - pad_pkg::OFF_BIAS_FIRST);

    // ************************************
    // Register writes
    // ************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            fb_lo_r <= pad_pkg::RST_BYTE;
            fb_hi_r <= pad_pkg::RST_BYTE;
            cal_ctrl_r <= pad_pkg::RST_BYTE;
            pre_to_r <= pad_pkg::RST_BYTE;
            cnt_to_r <= pad_pkg::RST_BYTE;
            set_to_r <= pad_pkg::RST_BYTE;
            phase_ctrl_r <= pad_pkg::RST_BYTE;
            init_lo_r <= pad_pkg::RST_BYTE;
            init_hi_r <= pad_pkg::RST_BYTE;
            step_r <= pad_pkg::RST_BYTE;
            for (int k = 0; k < 4; k++) frac1_r[k] <= pad_pkg::RST_BYTE;
            for (int k = 0; k < 3; k++) begin
                frac2_r[k] <= pad_pkg::RST_BYTE;
                mod2_r[k] <= pad_pkg::RST_BYTE;
            end
        end else if (link.reg_wr) begin
            case (link.reg_addr)
                pad_pkg::OFF_FB_INT_LOW:     fb_lo_r <= link.reg_wdata;
                pad_pkg::OFF_FB_INT_HIGH:    fb_hi_r <= link.reg_wdata;
                pad_pkg::OFF_FRAC1_0:        frac1_r[0] <= link.reg_wdata;
                pad_pkg::OFF_FRAC1_1:        frac1_r[1] <= link.reg_wdata;
                pad_pkg::OFF_FRAC1_2:        frac1_r[2] <= link.reg_wdata;
                pad_pkg::OFF_FRAC1_3:        frac1_r[3] <= link.reg_wdata;
                pad_pkg::OFF_FRAC2_0:        frac2_r[0] <= link.reg_wdata;
                pad_pkg::OFF_FRAC2_1:        frac2_r[1] <= link.reg_wdata;
                pad_pkg::OFF_FRAC2_2:        frac2_r[2] <= link.reg_wdata;
                pad_pkg::OFF_MOD2_0:         mod2_r[0] <= link.reg_wdata;
                pad_pkg::OFF_MOD2_1:         mod2_r[1] <= link.reg_wdata;
                pad_pkg::OFF_MOD2_2:         mod2_r[2] <= link.reg_wdata;
                pad_pkg::OFF_CAL_CTRL:       cal_ctrl_r <= link.reg_wdata;
                pad_pkg::OFF_PRECHARGE_TO:   pre_to_r <= link.reg_wdata;
                pad_pkg::OFF_BAND_COUNT_TO:  cnt_to_r <= link.reg_wdata;
                pad_pkg::OFF_BAND_SETTLE_TO: set_to_r <= link.reg_wdata;
                pad_pkg::OFF_PHASE_CTRL:     phase_ctrl_r <= {1'b0, link.reg_wdata[6:0]};
                pad_pkg::OFF_INIT_PHASE_LO:  init_lo_r <= link.reg_wdata;
                pad_pkg::OFF_INIT_PHASE_HI:  init_hi_r <= link.reg_wdata;
                pad_pkg::OFF_PHASE_STEP:     step_r <= link.reg_wdata;
                default: ;
            endcase
        end
    end

    // ************************************
    // Core bias table, writable only while i_init_done is low
    // ************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int k = 0; k < pad_pkg::BIAS_DEPTH; k++) bias_r[k] <= pad_pkg::RST_BYTE;
        end else if (link.reg_wr && bias_hit && !i_init_done) begin
            bias_r[bias_idx] <= link.reg_wdata;
        end
    end

    // ************************************
    // Autocalibration timer
    // ************************************
    typedef enum {CAL_IDLE, CAL_PRE, CAL_START, CAL_SETTLE, CAL_COUNT, CAL_EXTRA,
                  CAL_VCAL} pad_cal_type;
    pad_cal_type cal_r;
    logic [7:0]       div_cnt_r;
    logic             tick;
    logic [CNT_W-1:0] cnt_r;
    logic [3:0]       band_r;
    logic [2:0]       shift;
    assign shift = cal_ctrl_r[1:0] + {1'b0, cal_ctrl_r[pad_pkg::POS_CAL_HALVING]};
    assign tick  = (div_cnt_r & ((8'h01 << shift) - 8'h01)) == 8'h00;

    always_ff @(posedge i_clk) begin
        if (i_reset || cal_r == CAL_IDLE) div_cnt_r <= 8'h01;
        else div_cnt_r <= div_cnt_r + 8'h01;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cal_r <= CAL_IDLE;
            cnt_r <= '0;
            band_r <= 4'h0;
        end else if (wr_fb_lo) begin
            cal_r <= CAL_PRE;
            cnt_r <= '0;
            band_r <= 4'h0;
        end else if (cal_r != CAL_IDLE && tick) begin
            cnt_r <= cnt_r + 1'b1;
            unique case (cal_r)
                CAL_PRE: if (cnt_r + 1'b1 >= CNT_W'(pre_to_r)) begin
                    cal_r <= CAL_START;
                    cnt_r <= '0;
                end
                CAL_START: if (cnt_r + 1'b1 >= CNT_W'(pad_pkg::CAL_START_PERIODS)) begin
                    cal_r <= CAL_SETTLE;
                    cnt_r <= '0;
                end
                CAL_SETTLE: if (cnt_r + 1'b1 >= CNT_W'(set_to_r)) begin
                    cal_r <= CAL_COUNT;
                    cnt_r <= '0;
                end
                CAL_COUNT: if (cnt_r + 1'b1 >= CNT_W'({cnt_to_r, 4'h0})) begin
                    cal_r <= CAL_EXTRA;
                    cnt_r <= '0;
                end
                CAL_EXTRA: if (cnt_r + 1'b1 >= CNT_W'(pad_pkg::CAL_BAND_EXTRA)) begin
                    cnt_r <= '0;
                    band_r <= band_r + 4'h1;
                    cal_r <= (band_r == 4'(pad_pkg::CAL_BAND_COUNT - 1)) ? CAL_VCAL
                                                                        : CAL_SETTLE;
                end
                CAL_VCAL: if (cnt_r + 1'b1 >= CNT_W'(pad_pkg::CAL_VCAL_PERIODS)) begin
                    cal_r <= CAL_IDLE;
                    cnt_r <= '0;
                end
                CAL_IDLE: ;
            endcase
        end
    end
    assign o_cal_busy = cal_r != CAL_IDLE;

    // ************************************
    // Divider outputs, lock loss
    // ************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_out_divisor <= 5'h01;
            o_out_invert <= 1'b0;
            o_fb_integer <= 12'h000;
            o_primary_fraction <= '0;
            o_auxiliary_fraction <= '0;
            o_auxiliary_modulus <= '0;
            o_lock_lost <= 1'b0;
        end else begin
            o_out_divisor <= div_of(fb_hi_r[7:pad_pkg::POS_OUTDIV]);
            o_out_invert <= fb_hi_r[pad_pkg::POS_INVERT];
            o_fb_integer <= {fb_hi_r[3:0], fb_lo_r};
            o_primary_fraction <= {frac1_r[3][0], frac1_r[2], frac1_r[1], frac1_r[0]};
            o_auxiliary_fraction <= {frac2_r[2], frac2_r[1], frac2_r[0]};
            o_auxiliary_modulus <= {mod2_r[2], mod2_r[1], mod2_r[0]};
            o_lock_lost <= (fb_hi_r[7:4] != {o_out_divisor == 5'h01 ? 3'h0 :
                           o_out_divisor == 5'h02 ? 3'h1 : o_out_divisor == 5'h04 ? 3'h2 :
                           o_out_divisor == 5'h08 ? 3'h3 : 3'h4, o_out_invert})
                           || o_cal_busy;
        end
    end

    // ************************************
    // Phase pins synchroniser
    // ************************************
    logic [2:0] stb_sync_r, dir_sync_r;
    logic       stb_r, dir_r, stb_fall, pin_dir;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            stb_sync_r <= 3'h0;
            dir_sync_r <= 3'h0;
            stb_r <= 1'b0;
            dir_r <= 1'b0;
        end else begin
            stb_sync_r <= {stb_sync_r[1:0], link.phase_strobe_pin};
            dir_sync_r <= {dir_sync_r[1:0], link.phase_direction_pin};
            if (stb_sync_r[2] == stb_sync_r[1]) stb_r <= stb_sync_r[2];
            if (dir_sync_r[2] == dir_sync_r[1] && stb_r) dir_r <= dir_sync_r[2];
        end
    end
    assign stb_fall = stb_r && stb_sync_r[2] == stb_sync_r[1] && !stb_sync_r[2];
    assign pin_dir  = dir_r;

    // ************************************
    // Phase accumulator and bleed level
    // ************************************
    logic ev, up, pin_ev;
    assign pin_ev = stb_fall && phase_ctrl_r[pad_pkg::POS_PIN_EN];
    // Software step acts one cycle late, with the control byte just written
    always_ff @(posedge i_clk) begin
        if (i_reset) sw_step_r <= 1'b0;
        else sw_step_r <= sw_step;
    end
    assign ev = (pin_ev || sw_step_r) && phase_ctrl_r[pad_pkg::POS_RESYNC];
    // Pin direction 1 means later; register direction bit sets sense per method
    assign up = pin_ev ? pin_dir
              : (phase_ctrl_r[pad_pkg::POS_METHOD] ? !phase_ctrl_r[pad_pkg::POS_DIRECTION]
                                                    : phase_ctrl_r[pad_pkg::POS_DIRECTION]);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            acc_r <= 14'h0000;
            bleed_r <= 8'h00;
        end else if (!i_init_done) begin
            acc_r <= {init_hi_r[5:0], init_lo_r};
            bleed_r <= 8'h00;
        end else if (ev && phase_ctrl_r[pad_pkg::POS_METHOD]) begin
            acc_r <= up ? (acc_r + {6'h00, step_r}) % pad_pkg::ACC_WRAP
                        : (acc_r - {6'h00, step_r}) % pad_pkg::ACC_WRAP;
        end else if (ev && phase_ctrl_r[pad_pkg::POS_BLEED_EN]) begin
            bleed_r <= up ? bleed_r + step_r : bleed_r - step_r;
        end
    end
    assign o_phase_offset = acc_r;
    assign o_bleed_level  = bleed_r;

    // ************************************
    // Register reads
    // ************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdata_r <= 8'h00;
            ack_r <= 1'b0;
        end else begin
            ack_r <= link.reg_wr || link.reg_rd;
            if (link.reg_rd) begin
                case (link.reg_addr)
                    pad_pkg::OFF_FB_INT_LOW:    rdata_r <= fb_lo_r;
                    pad_pkg::OFF_FB_INT_HIGH:   rdata_r <= fb_hi_r;
                    pad_pkg::OFF_CAL_CTRL:      rdata_r <= cal_ctrl_r;
                    pad_pkg::OFF_PHASE_CTRL:    rdata_r <= phase_ctrl_r;
                    pad_pkg::OFF_PHASE_STEP:    rdata_r <= step_r;
                    pad_pkg::OFF_STATUS:        rdata_r <= {4'h0, o_cal_busy, 3'h0};
                    pad_pkg::OFF_ACC_PHASE_LO:  rdata_r <= acc_r[7:0];
                    pad_pkg::OFF_ACC_PHASE_HI:  rdata_r <= {2'b00, acc_r[13:8]};
                    pad_pkg::OFF_BLEED_LEVEL:   rdata_r <= bleed_r;
                    default: rdata_r <= bias_hit ? bias_r[bias_idx] : 8'h00;
                endcase
            end
        end
    end
    assign link.reg_rdata = rdata_r;
    assign link.reg_ack   = ack_r;
endmodule
`default_nettype wire

// ==== core/pad_pkg.sv ====
// Package of shared constants for the phase adjust / divider control block
// Assumes a 125 MHz system clock on both ends
package pad_pkg;
    // Register offsets (byte-wide device registers)
    localparam logic [8:0] OFF_FB_INT_LOW     = 9'h010;
    localparam logic [8:0] OFF_FB_INT_HIGH    = 9'h011;
    localparam logic [8:0] OFF_FRAC1_0        = 9'h012;
    localparam logic [8:0] OFF_FRAC1_1        = 9'h013;
    localparam logic [8:0] OFF_FRAC1_2        = 9'h014;
    localparam logic [8:0] OFF_FRAC1_3        = 9'h015;
    localparam logic [8:0] OFF_FRAC2_0        = 9'h017;
    localparam logic [8:0] OFF_FRAC2_1        = 9'h018;
    localparam logic [8:0] OFF_FRAC2_2        = 9'h019;
    localparam logic [8:0] OFF_MOD2_0         = 9'h01A;
    localparam logic [8:0] OFF_MOD2_1         = 9'h01B;
    localparam logic [8:0] OFF_MOD2_2         = 9'h01C;
    localparam logic [8:0] OFF_CAL_CTRL       = 9'h020;
    localparam logic [8:0] OFF_PRECHARGE_TO   = 9'h021;
    localparam logic [8:0] OFF_BAND_COUNT_TO  = 9'h022;
    localparam logic [8:0] OFF_BAND_SETTLE_TO = 9'h023;
    localparam logic [8:0] OFF_PHASE_CTRL     = 9'h030;
    localparam logic [8:0] OFF_INIT_PHASE_LO  = 9'h031;
    localparam logic [8:0] OFF_INIT_PHASE_HI  = 9'h032;
    localparam logic [8:0] OFF_PHASE_STEP     = 9'h033;
    localparam logic [8:0] OFF_STATUS         = 9'h058;
    localparam logic [8:0] OFF_ACC_PHASE_LO   = 9'h061;
    localparam logic [8:0] OFF_ACC_PHASE_HI   = 9'h062;
    localparam logic [8:0] OFF_BLEED_LEVEL    = 9'h063;
    localparam logic [8:0] OFF_BIAS_FIRST     = 9'h100;
    localparam logic [8:0] OFF_BIAS_LAST      = 9'h111;
    localparam int         BIAS_DEPTH         = 18;
    // Field positions
    localparam int POS_INVERT       = 4;
    localparam int POS_OUTDIV       = 5;
    localparam int POS_CAL_HALVING  = 2;
    localparam int POS_METHOD       = 0;
    localparam int POS_DIRECTION    = 1;
    localparam int POS_RESYNC       = 2;
    localparam int POS_BLEED_EN     = 3;
    localparam int POS_PIN_EN       = 4;
    localparam int POS_SW_STEP      = 7;
    localparam int POS_CAL_BUSY     = 3;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Fixed primary modulus exponent, accumulator wrap point
    localparam int         PRIMARY_MOD_LOG2 = 25;
    localparam logic [13:0] ACC_WRAP        = 14'h2000;
    // Calibration fixed terms in divided-clock periods, and the number of bands
    localparam int CAL_START_PERIODS = 2;
    localparam int CAL_BAND_EXTRA    = 5;
    localparam int CAL_BAND_COUNT    = 10;
    localparam int CAL_VCAL_PERIODS  = 2;
    // Controller APB address width
    localparam int APB_ADDR_W = 12;
endpackage

// ==== core/pad_link_if.sv ====
// Interface joining the controller to the device: parallel register port and phase pins
// Assumes both ends share i_clk
`timescale 1ns/1ps
`default_nettype none
interface pad_link_if;
    logic       reg_wr;
    logic       reg_rd;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_ack;
    logic       phase_strobe_pin;
    logic       phase_direction_pin;
    modport device (input  reg_wr, reg_rd, reg_addr, reg_wdata, phase_strobe_pin,
                           phase_direction_pin,
                    output reg_rdata, reg_ack);
    modport host   (output reg_wr, reg_rd, reg_addr, reg_wdata, phase_strobe_pin,
                           phase_direction_pin,
                    input  reg_rdata, reg_ack);
endinterface
`default_nettype wire

// ==== core/pad_host.sv ====
// Controller end: APB slave with command registers, drives device port and phase pins
// Assumes the device answers a register access one cycle later
`timescale 1ns/1ps
`default_nettype none
module pad_host (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    pad_link_if.host         link
);
    // ************************************
    // Own registers: 0x0 command, 0x4 pin control, 0x8 status
    // ************************************
    localparam logic [11:0] HOFF_CMD  = 12'h000;
    localparam logic [11:0] HOFF_PINS = 12'h004;
    localparam logic [11:0] HOFF_STAT = 12'h008;
    logic        acc, busy_r, rd_r, wr_r, done_r;
    logic [8:0]  addr_r;
    logic [7:0]  wdata_r, rdata_r;
    logic [1:0]  pins_r;

    assign acc = i_psel && i_penable;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            busy_r <= 1'b0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= 9'h000;
            wdata_r <= 8'h00;
            rdata_r <= 8'h00;
            done_r <= 1'b0;
        end else begin
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            if (link.reg_ack && busy_r) begin
                busy_r <= 1'b0;
                rdata_r <= link.reg_rdata;
                done_r <= 1'b1;
            end
            if (acc && i_pwrite && i_paddr == HOFF_CMD && !busy_r) begin
                // Bits: [7:0] data, [16:8] address, [24] read
                addr_r <= i_pwdata[16:8];
                wdata_r <= i_pwdata[7:0];
                rd_r <= i_pwdata[24];
                wr_r <= !i_pwdata[24];
                busy_r <= 1'b1;
                done_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) pins_r <= 2'b00;
        else if (acc && i_pwrite && i_paddr == HOFF_PINS) pins_r <= i_pwdata[1:0];
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) o_prdata <= 32'h0000_0000;
        else if (i_psel && !i_penable && !i_pwrite) begin
            case (i_paddr)
                HOFF_CMD:  o_prdata <= {7'h00, rd_r, 7'h00, addr_r, wdata_r};
                HOFF_PINS: o_prdata <= {30'h0000_0000, pins_r};
                HOFF_STAT: o_prdata <= {22'h00_0000, busy_r, done_r, rdata_r};
                default:   o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign o_pready  = 1'b1;
    assign o_pslverr = acc && !(i_paddr == HOFF_CMD || i_paddr == HOFF_PINS
                                || i_paddr == HOFF_STAT);
    assign link.reg_wr = wr_r;
    assign link.reg_rd = rd_r;
    assign link.reg_addr = addr_r;
    assign link.reg_wdata = wdata_r;
    assign link.phase_strobe_pin = pins_r[0];
    assign link.phase_direction_pin = pins_r[1];
endmodule
`default_nettype wire

// ==== test/pad_props.sv ====
// Checker on the controller to device link
// Assumes it is instantiated beside the link interface
`timescale 1ns/1ps
`default_nettype none
module pad_props (
    input wire logic       i_clk,
    input wire logic       i_reset,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_ack,
    input wire logic       phase_strobe_pin,
    input wire logic       phase_direction_pin
);
    // ****
    // Link properties
    // ****
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence req_s; reg_wr || reg_rd; endsequence
    sequence ack_s; ##1 reg_ack; endsequence
    ack_follows_a: assert property (req_s |-> ack_s)
        else $error("link request without ack");
    ack_cause_a: assert property (reg_ack |-> $past(reg_wr || reg_rd))
        else $error("ack without request");
    req_excl_a: assert property (!(reg_wr && reg_rd))
        else $error("read and write together");
    req_pulse_a: assert property (reg_wr |=> !reg_wr)
        else $error("write pulse too long");
    unmapped_zero_a: assert property (reg_rd && reg_addr == 9'h0FF |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    strobe_high_a: assert property ($rose(phase_strobe_pin) |-> phase_strobe_pin [*3])
        else $error("strobe high too short");
    strobe_low_a: assert property ($fell(phase_strobe_pin) |-> !phase_strobe_pin [*3])
        else $error("strobe low too short");
    dir_hold_a: assert property (phase_strobe_pin && $past(phase_strobe_pin)
        |-> $stable(phase_direction_pin))
        else $error("direction moved under strobe");
endmodule
`default_nettype wire

// ==== test/tb_pll_phase_adjust_divider_ctrl.sv ====
// Bench driving the controller over APB and watching the device outputs
// Assumes the package, interface, both ends and pad_props compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
$display("unexpected %0t mismatch", $time); end end
module tb_pll_phase_adjust_divider_ctrl;
    logic        i_clk, i_reset, psel, penable, pwrite, init_done, slverr, lost_seen;
    logic        pready, pslverr, cal_busy, out_invert, lock_lost;
    logic [11:0] paddr, fb_integer;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  out_divisor;
    logic [24:0] prim_frac;
    logic [13:0] phase_offset;
    logic [7:0]  bleed_level;
    logic [23:0] aux_frac, aux_mod;
    int          failures = 0, total_checks = 0, ticks = 0, cal_cnt = 0;
    pad_link_if link ();
    pad_host pad_host_i (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .link(link));
    pad_device pad_device_i (.i_clk(i_clk), .i_reset(i_reset), .link(link),
        .i_init_done(init_done), .o_cal_busy(cal_busy), .o_out_divisor(out_divisor),
        .o_out_invert(out_invert), .o_fb_integer(fb_integer), .o_primary_fraction(prim_frac),
        .o_auxiliary_fraction(aux_frac), .o_auxiliary_modulus(aux_mod), .o_lock_lost(lock_lost),
        .o_phase_offset(phase_offset), .o_bleed_level(bleed_level));
    pad_props pad_props_i (.i_clk(i_clk), .i_reset(i_reset), .reg_wr(link.reg_wr),
        .reg_rd(link.reg_rd), .reg_addr(link.reg_addr), .reg_rdata(link.reg_rdata),
        .reg_ack(link.reg_ack), .phase_strobe_pin(link.phase_strobe_pin),
        .phase_direction_pin(link.phase_direction_pin));
    // ****
    // Clock, watchdog and tasks
    // ****
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    task automatic complete_run;
        if (failures == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge i_clk) begin
        ticks++;
        if (cal_busy === 1'b1) cal_cnt <= cal_cnt + 1;
        if (lock_lost === 1'b1) lost_seen = 1'b1;
        if (ticks == 30000) begin
            failures++;
            complete_run();
        end
    end
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        @(posedge i_clk);
        while (pready !== 1'b1) @(posedge i_clk);
        slverr  = pslverr;
        rd      = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic dev(input logic wr, input logic [8:0] a, input logic [7:0] d);
        int n;
        apb(1'b1, 12'h000, {7'h00, ~wr, 7'h00, a, d});
        n = 0;
        do begin
            apb(1'b0, 12'h008, 32'h0000_0000);
            n++;
        end while (rd[9] !== 1'b0 && n < 20);
        if (rd[9] !== 1'b0) begin
            failures++;
            $display("unexpected %0t device access hung", $time);
        end
    endtask
    task automatic pulse(input logic dir);
        apb(1'b1, 12'h004, {30'h0000_0000, dir, 1'b1});
        repeat (6) @(posedge i_clk);
        apb(1'b1, 12'h004, {30'h0000_0000, dir, 1'b0});
        repeat (8) @(posedge i_clk);
    endtask
    // ****
    // Main sequence
    // ****
    initial begin
        int n;
        {psel, penable, pwrite, init_done, lost_seen} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        i_reset = 1'b1;
        repeat (16) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        `CHK(out_divisor, 5'h01)
        dev(1'b1, 9'h101, 8'h5A);
        dev(1'b1, 9'h031, 8'hF0);
        dev(1'b1, 9'h032, 8'h1F);
        `CHK(phase_offset, 14'h1FF0)
        init_done <= 1'b1;
        dev(1'b1, 9'h101, 8'h00);
        dev(1'b0, 9'h101, 8'h00);
        `CHK(rd[7:0], 8'h5A)
        apb(1'b1, 12'h0FC, 32'h0000_0000);
        `CHK(slverr, 1'b1)
        dev(1'b0, 9'h0FF, 8'h00);
        `CHK(rd[7:0], 8'h00)
        dev(1'b1, 9'h033, 8'h20);
        dev(1'b1, 9'h030, 8'h85);
        `CHK(phase_offset, 14'h0010)
        dev(1'b1, 9'h030, 8'h87);
        `CHK(phase_offset, 14'h1FF0)
        dev(1'b0, 9'h061, 8'h00);
        `CHK(rd[7:0], 8'hF0)
        pulse(1'b1);
        `CHK(phase_offset, 14'h1FF0)
        dev(1'b1, 9'h030, 8'h15);
        pulse(1'b1);
        `CHK(phase_offset, 14'h0010)
        pulse(1'b0);
        `CHK(phase_offset, 14'h1FF0)
        dev(1'b1, 9'h030, 8'h8E);
        `CHK(bleed_level, 8'h20)
        dev(1'b0, 9'h063, 8'h00);
        `CHK(rd[7:0], 8'h20)
        dev(1'b1, 9'h030, 8'h8C);
        `CHK(bleed_level, 8'h00)
        for (int k = 0; k < 4; k++) dev(1'b1, 9'h012 + 9'(k), 8'(32'h0133_2211 >> (8 * k)));
        for (int k = 0; k < 6; k++) dev(1'b1, 9'h017 + 9'(k), 8'(k + 1));
        dev(1'b1, 9'h021, 8'h03);
        dev(1'b1, 9'h022, 8'h01);
        dev(1'b1, 9'h023, 8'h02);
        for (int k = 0; k < 5; k++) begin
            dev(1'b1, 9'h020, k[0] ? 8'h04 : 8'h01);
            dev(1'b1, 9'h011, {k[2:0], 1'b1, 4'h3});
            cal_cnt <= 0;
            dev(1'b1, 9'h010, 8'h45);
            dev(1'b0, 9'h058, 8'h00);
            `CHK(rd[3], 1'b1)
            n = 0;
            while (cal_busy === 1'b1 && n < 3000) begin
                @(posedge i_clk);
                n++;
            end
            @(posedge i_clk);
            `CHK(cal_cnt, 474)
            `CHK(out_divisor, 5'h01 << k)
            `CHK(out_invert, 1'b1)
            `CHK(fb_integer, 12'h345)
        end
        `CHK(prim_frac, 25'h133_2211)
        `CHK(aux_frac, 24'h03_0201)
        `CHK(aux_mod, 24'h06_0504)
        `CHK(lost_seen, 1'b1)
        complete_run();
    end
endmodule
`default_nettype wire
